// file: core/stwc_pkg.sv
// Purpose : shared constants and types for the stop-wake / port-config block
// Assumes : 250 MHz system clock, 8-bit expanded register file access from the core
// Notes   : all offsets, reset values and cycle counts live here

package stwc_pkg;

    // ------------------------------------------------------------------
    // register locations (expanded register bank F)
    // ------------------------------------------------------------------
    localparam logic [3:0] STWC_CFG_BANK      = 4'hf;   // bank holding system config
    localparam logic [3:0] STWC_OFF_PORTDRV   = 4'h0;   // port_drive_config, write only
    localparam logic [3:0] STWC_OFF_STOPWAKE  = 4'h1;   // stop_wake_control
    localparam logic [3:0] STWC_OFF_WDMODE    = 4'h2;   // watchdog_mode_reg
    localparam logic [3:0] STWC_OFF_P2MODE    = 4'h3;   // port2_mode_reg
    localparam logic [3:0] STWC_OFF_P3MODE    = 4'h4;   // port3_mode_reg

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int STWC_PD_CMP_OUT    = 0;  // comparator outputs onto port 3
    localparam int STWC_PD_P2_STD     = 5;  // port 2 standard drive
    localparam int STWC_PD_P3_STD     = 6;  // port 3 standard drive
    localparam int STWC_PD_OSC_STD    = 7;  // oscillator standard drive
    localparam int STWC_SW_SRC_LSB    = 2;  // wake source select, 3 bits
    localparam int STWC_SW_DELAY_EN   = 5;  // post-wake long delay enable
    localparam int STWC_SW_LEVEL_HI   = 6;  // wake on high level
    localparam int STWC_SW_WARM       = 7;  // warm start flag, read only
    localparam int STWC_P3M_ANALOG    = 1;  // port 3 bits 1..3 in analog mode

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] STWC_PORTDRV_RST  = 8'hfe;  // standard drive, no comparator out
    localparam logic [7:0] STWC_STOPWAKE_RST = 8'h20;  // delay on, low level, cold
    localparam logic [7:0] STWC_WDMODE_RST   = 8'h00;
    localparam logic [7:0] STWC_P2MODE_RST   = 8'h00;
    localparam logic [7:0] STWC_P3MODE_RST   = 8'h00;
    localparam logic [7:0] STWC_RD_WO       = 8'h00;  // read value of write-only location

    // ------------------------------------------------------------------
    // wake source codes
    // ------------------------------------------------------------------
    localparam logic [2:0] STWC_SRC_P31     = 3'h2;
    localparam logic [2:0] STWC_SRC_P32     = 3'h3;
    localparam logic [2:0] STWC_SRC_P33     = 3'h4;
    localparam logic [2:0] STWC_SRC_P27     = 3'h5;
    localparam logic [2:0] STWC_SRC_NOR_LO  = 3'h6;
    localparam logic [2:0] STWC_SRC_NOR_ALL = 3'h7;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int STWC_CLK_KHZ        = 250000;  // system clock rate
    localparam int STWC_RST_DELAY_MS   = 5;       // nominal reset delay
    localparam int STWC_RST_DELAY_CYC  = STWC_RST_DELAY_MS * STWC_CLK_KHZ;
    localparam int STWC_TAIL_CYC       = 18;      // clocks after the delay
    localparam int STWC_CNT_W          = 21;      // counter width for the delay

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        STWC_HOLD,
        STWC_DELAY,
        STWC_TAIL,
        STWC_RUN,
        STWC_STOP
    } stwc_state_t;

endpackage

// file: core/stwc_top.sv
// Purpose : reset sequencing, stop-mode wake-up and port / oscillator drive configuration
// Assumes : core writes config registers over a simple bank/offset strobe port
// Notes   : long reset delay is a parameter so simulation can shorten it

`timescale 1ns/1ps

// How it works
// - reset on power-on, watchdog, wake, low-voltage
// - power-on reset holds delay plus 18 clocks
// - wake reset keeps mode and recovery registers
// - config bit 0 routes comparators to port 3
// - config bit 5 low-noise port 2, default 1
// - config bit 6 low-noise port 3, default 1
// - config bit 7 oscillator drive, ratio unchanged
// - config register write only, bank F 00
// - recovery bits 4..2 pick wake source
// - analog port 3 inputs never wake
// - serial compare match always wakes
// - recovery bit 5 enables delay, default 1
// - bit 5 set applies delay, clear fast
// - recovery bit 6 selects wake level, default 0
// - bit 7 read-only warm flag, set on stop
module stwc_top
#(
    parameter int DELAY_CYCLES = stwc_pkg::STWC_RST_DELAY_CYC,  // long reset delay
    parameter int TAIL_CYCLES  = stwc_pkg::STWC_TAIL_CYC        // clocks after delay
)
(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       por_detect,
    input  wire logic       lvp_detect,
    input  wire logic       wdt_expire,
    input  wire logic       stop_req,
    input  wire logic [3:0] reg_bank,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    output logic      [7:0] reg_rdata,
    input  wire logic [7:0] port2_pins,
    input  wire logic [3:1] port3_pins,
    input  wire logic       spi_enable,
    input  wire logic       spi_cmp_enable,
    input  wire logic       spi_cmp_match,
    input  wire logic       cmp_out_a,
    input  wire logic       cmp_out_b,
    input  wire logic       port3_bit4_gpio,
    input  wire logic       port3_bit5_gpio,
    output logic            port3_bit4_out,
    output logic            port3_bit5_out,
    output logic            port2_low_noise,
    output logic            port3_low_noise,
    output logic            osc_low_noise,
    output logic      [7:0] watchdog_mode_reg,
    output logic      [7:0] port2_mode_reg,
    output logic      [7:0] port3_mode_reg,
    output logic            core_reset_n,
    output logic            stop_mode
);
    import stwc_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    stwc_state_t            state;            // sequencer state
    stwc_state_t            next_state;
    logic [STWC_CNT_W-1:0]  cnt;              // delay / tail counter
    logic [STWC_CNT_W-1:0]  next_cnt;
    logic [7:0]             port_drive_config;
    logic [7:0]             next_port_drive_config;
    logic [7:0]             stop_wake_control;
    logic [7:0]             next_stop_wake_control;
    logic [7:0]             next_watchdog_mode_reg;
    logic [7:0]             next_port2_mode_reg;
    logic [7:0]             next_port3_mode_reg;
    logic [7:0]             next_reg_rdata;
    logic                   next_p34;
    logic                   next_p35;
    logic [1:0]             pin_meta;         // por / lvp first stage
    logic [1:0]             pin_sync;         // por / lvp second stage
    logic                   pin_hit;          // wake pin at its level
    logic                   wake_event;       // qualified wake in stop
    logic                   cold_cause;       // power-on, low-voltage, watchdog

    localparam logic [STWC_CNT_W-1:0] DELAY_LAST = STWC_CNT_W'(DELAY_CYCLES - 1);
    localparam logic [STWC_CNT_W-1:0] TAIL_LAST  = STWC_CNT_W'(TAIL_CYCLES - 1);

    // decode of one config register address, used for every register
    function automatic logic hit(input logic [3:0] bank,
                                 input logic [3:0] addr,
                                 input logic [3:0] off);
        return (bank == STWC_CFG_BANK) && (addr == off);
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers for the analog detectors
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            pin_meta <= 2'b00;
            pin_sync <= 2'b00;
        end
        else
        begin
            pin_meta <= {lvp_detect, por_detect};
            pin_sync <= pin_meta;
        end
    end

    // ------------------------------------------------------------------
    // wake source selector
    // ------------------------------------------------------------------
    stwc_wake_sel u_wake_sel
    (
        .clk_sys     (clk_sys),
        .rstn        (rstn),
        .port2_pins  (port2_pins),
        .port3_pins  (port3_pins),
        .source_sel  (stop_wake_control[STWC_SW_SRC_LSB +: 3]),
        .level_high  (stop_wake_control[STWC_SW_LEVEL_HI]),
        .analog_mode (port3_mode_reg[STWC_P3M_ANALOG]),
        .wake_hit    (pin_hit)
    );

    // ------------------------------------------------------------------
    // reset causes and wake qualification
    // ------------------------------------------------------------------
    always_comb
    begin
        // cold causes restart everything, registers included
        cold_cause = pin_sync[0] | pin_sync[1] | wdt_expire;
        // sources only count while stopped; serial compare ignores the select field
        wake_event = (state == STWC_STOP)
                   & (pin_hit | (spi_enable & spi_cmp_enable & spi_cmp_match));
    end

    // ------------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_cnt   = cnt;
        if (cold_cause)
        begin
            // held while the cause stands, delay counted from its release
            next_state = STWC_HOLD;
            next_cnt   = '0;
        end
        else
        begin
            unique case (state)
                STWC_HOLD :
                begin
                    next_state = STWC_DELAY;
                    next_cnt   = '0;
                end
                STWC_DELAY :
                begin
                    if (cnt == DELAY_LAST)
                    begin
                        next_state = STWC_TAIL;
                        next_cnt   = '0;
                    end
                    else
                    begin
                        next_cnt = cnt + 1'b1;
                    end
                end
                STWC_TAIL :
                begin
                    if (cnt == TAIL_LAST)
                    begin
                        next_state = STWC_RUN;
                        next_cnt   = '0;
                    end
                    else
                    begin
                        next_cnt = cnt + 1'b1;
                    end
                end
                STWC_RUN :
                begin
                    if (stop_req)
                    begin
                        next_state = STWC_STOP;
                    end
                end
                STWC_STOP :
                begin
                    if (wake_event)
                    begin
                        // bit 5 set: long delay; clear: fast wake, tail only
                        next_state = stop_wake_control[STWC_SW_DELAY_EN]
                                   ? STWC_DELAY : STWC_TAIL;
                        next_cnt   = '0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // register file next values
    // ------------------------------------------------------------------
    always_comb
    begin
        next_port_drive_config = port_drive_config;
        next_stop_wake_control = stop_wake_control;
        next_watchdog_mode_reg = watchdog_mode_reg;
        next_port2_mode_reg    = port2_mode_reg;
        next_port3_mode_reg    = port3_mode_reg;
        if (cold_cause)
        begin
            // only cold causes restore defaults; a wake leaves them alone
            next_port_drive_config = STWC_PORTDRV_RST;
            next_stop_wake_control = STWC_STOPWAKE_RST;
            next_watchdog_mode_reg = STWC_WDMODE_RST;
            next_port2_mode_reg    = STWC_P2MODE_RST;
            next_port3_mode_reg    = STWC_P3MODE_RST;
        end
        else
        begin
            if (reg_wr && core_reset_n)
            begin
                if (hit(reg_bank, reg_addr, STWC_OFF_PORTDRV))
                begin
                    // bits 4..1 stored as written; software keeps them at one
                    next_port_drive_config = reg_wdata;
                end
                if (hit(reg_bank, reg_addr, STWC_OFF_STOPWAKE))
                begin
                    next_stop_wake_control[6:0] = reg_wdata[6:0];
                end
                if (hit(reg_bank, reg_addr, STWC_OFF_WDMODE))
                begin
                    next_watchdog_mode_reg = reg_wdata;
                end
                if (hit(reg_bank, reg_addr, STWC_OFF_P2MODE))
                begin
                    next_port2_mode_reg = reg_wdata;
                end
                if (hit(reg_bank, reg_addr, STWC_OFF_P3MODE))
                begin
                    next_port3_mode_reg = reg_wdata;
                end
            end
            // warm flag set by hardware on stop entry; no software clear
            if ((state == STWC_RUN) && stop_req)
            begin
                next_stop_wake_control[STWC_SW_WARM] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // read data and pin routing next values
    // ------------------------------------------------------------------
    always_comb
    begin
        next_reg_rdata = 8'h00;
        if (hit(reg_bank, reg_addr, STWC_OFF_PORTDRV))
        begin
            next_reg_rdata = STWC_RD_WO;  // write only, contents hidden
        end
        else if (hit(reg_bank, reg_addr, STWC_OFF_STOPWAKE))
        begin
            next_reg_rdata = stop_wake_control;
        end
        else if (hit(reg_bank, reg_addr, STWC_OFF_WDMODE))
        begin
            next_reg_rdata = watchdog_mode_reg;
        end
        else if (hit(reg_bank, reg_addr, STWC_OFF_P2MODE))
        begin
            next_reg_rdata = port2_mode_reg;
        end
        else if (hit(reg_bank, reg_addr, STWC_OFF_P3MODE))
        begin
            next_reg_rdata = port3_mode_reg;
        end
        // comparator outputs replace ordinary port data when bit 0 set
        next_p34 = port_drive_config[STWC_PD_CMP_OUT] ? cmp_out_a : port3_bit4_gpio;
        next_p35 = port_drive_config[STWC_PD_CMP_OUT] ? cmp_out_b : port3_bit5_gpio;
    end

    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            state             <= STWC_HOLD;  // system reset acts as power-on
            cnt               <= '0;
            port_drive_config <= STWC_PORTDRV_RST;
            stop_wake_control <= STWC_STOPWAKE_RST;
            watchdog_mode_reg <= STWC_WDMODE_RST;
            port2_mode_reg    <= STWC_P2MODE_RST;
            port3_mode_reg    <= STWC_P3MODE_RST;
            reg_rdata         <= 8'h00;
            port3_bit4_out    <= 1'b0;
            port3_bit5_out    <= 1'b0;
        end
        else
        begin
            state             <= next_state;
            cnt               <= next_cnt;
            port_drive_config <= next_port_drive_config;
            stop_wake_control <= next_stop_wake_control;
            watchdog_mode_reg <= next_watchdog_mode_reg;
            port2_mode_reg    <= next_port2_mode_reg;
            port3_mode_reg    <= next_port3_mode_reg;
            reg_rdata         <= next_reg_rdata;
            port3_bit4_out    <= next_p34;
            port3_bit5_out    <= next_p35;
        end
    end

    // ------------------------------------------------------------------
    // drive selects and status outputs
    // ------------------------------------------------------------------
    // drive selects are inverted register bits; oscillator ratio is untouched here
    always_comb
    begin
        port2_low_noise = ~port_drive_config[STWC_PD_P2_STD];
        port3_low_noise = ~port_drive_config[STWC_PD_P3_STD];
        osc_low_noise   = ~port_drive_config[STWC_PD_OSC_STD];
        core_reset_n    = (state == STWC_RUN) || (state == STWC_STOP);
        stop_mode       = (state == STWC_STOP);
    end

endmodule

// file: core/stwc_wake_sel.sv
// Purpose : synchronise wake pins and pick the selected stop-mode wake source
// Assumes : pins are asynchronous to clk_sys
// Notes   : output is a level, true while the chosen source is at its wake level

`timescale 1ns/1ps

module stwc_wake_sel
(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic [7:0] port2_pins,
    input  wire logic [3:1] port3_pins,
    input  wire logic [2:0] source_sel,
    input  wire logic       level_high,
    input  wire logic       analog_mode,
    output logic            wake_hit
);
    import stwc_pkg::*;

    // ------------------------------------------------------------------
    // two-stage synchronisers
    // ------------------------------------------------------------------
    logic [10:0] meta;        // first stage, read only by second stage
    logic [10:0] sync;        // second stage, safe to use
    logic [10:0] next_meta;
    logic [10:0] next_sync;

    // next values of the synchroniser chain
    always_comb
    begin
        next_meta = {port3_pins, port2_pins};
        next_sync = meta;
    end

    // register the chain
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            meta <= 11'h7ff;  // idle high so no false low-level wake
            sync <= 11'h7ff;
        end
        else
        begin
            meta <= next_meta;
            sync <= next_sync;
        end
    end

    // ------------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------------
    // returns the raw level of the chosen source and whether it is usable
    function automatic logic [1:0] pick(input logic [2:0] sel,
                                        input logic [7:0] p2,
                                        input logic [3:1] p3,
                                        input logic       ana);
        logic [1:0] r;
        r = 2'b00;
        unique case (sel)
            STWC_SRC_P31     : r = {~ana, p3[1]};
            STWC_SRC_P32     : r = {~ana, p3[2]};
            STWC_SRC_P33     : r = {~ana, p3[3]};
            STWC_SRC_P27     : r = {1'b1, p2[7]};
            STWC_SRC_NOR_LO  : r = {1'b1, ~|p2[3:0]};
            STWC_SRC_NOR_ALL : r = {1'b1, ~|p2};
            default          : r = 2'b00;  // codes 0 and 1: no pin source; only serial compare or a cold cause ends stop
        endcase
        return r;
    endfunction

    logic [1:0] chosen;  // {usable, level}

    // wake when the usable source sits at the programmed level
    always_comb
    begin
        chosen   = pick(source_sel, sync[7:0], sync[10:8], analog_mode);
        wake_hit = chosen[1] & (chosen[0] == level_high);
    end

endmodule

// file: tb/stwc_pins_model.sv
// Purpose : far-side pin model that drives the port wake levels
// Assumes : the bench gives the idle and wake patterns as {port 2, port 3 bits 3..1}
// Notes   : the wake pattern is held 8 clocks so that a fast wake is always long enough
`timescale 1ns/1ps
module stwc_pins_model
(
    input  wire logic        clk_sys,
    input  wire logic        go,
    input  wire logic [10:0] idle_v,
    input  wire logic [10:0] wake_v,
    output logic      [7:0]  port2_pins,
    output logic      [3:1]  port3_pins
);
    logic [3:0] hold = 4'h0; // clocks left at wake level
    // hold the wake level eight clocks, then fall back to idle
    always @(posedge clk_sys)
        hold <= go ? 4'h8 : (hold != 4'h0 ? hold - 4'h1 : 4'h0);
    assign {port2_pins, port3_pins} = (hold != 4'h0) ? wake_v : idle_v;
endmodule

// file: tb/stwc_top_assertions.sv
// Purpose : port-level checks of reset sequencing, wake-up and drive config
// Assumes : detector inputs stay low while registers are written
// Notes   : sees only the top module ports
`timescale 1ns/1ps
module stwc_top_assertions
(
    input wire logic       clk_sys, rstn, wdt_expire, stop_req, reg_wr,
    input wire logic [3:0] reg_bank, reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata, watchdog_mode_reg, port2_mode_reg, port3_mode_reg,
    input wire logic       spi_enable, spi_cmp_enable, spi_cmp_match, core_reset_n, stop_mode,
    input wire logic       port2_low_noise, port3_low_noise, osc_low_noise
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic pd_wr; // a write that the config register takes
    assign pd_wr = reg_wr && core_reset_n && !wdt_expire && reg_bank == 4'hf && reg_addr == 4'h0;
    a_p2_drive: assert property (pd_wr |=> port2_low_noise == !$past(reg_wdata[5]))
        else $error("port 2 drive mismatch");
    a_p3_drive: assert property (pd_wr |=> port3_low_noise == !$past(reg_wdata[6]))
        else $error("port 3 drive mismatch");
    a_osc_drive: assert property (pd_wr |=> osc_low_noise == !$past(reg_wdata[7]))
        else $error("oscillator drive mismatch");
    a_wo_read: assert property (reg_bank != 4'hf || reg_addr == 4'h0 |=> reg_rdata == 8'h00)
        else $error("write-only or unmapped read not zero");
    a_boot_delay: assert property ($rose(rstn) |-> !core_reset_n [*8] ##[27:34] core_reset_n)
        else $error("boot delay wrong");
    a_stop_entry: assert property (stop_req && core_reset_n && !stop_mode && !wdt_expire |=> stop_mode)
        else $error("stop not entered");
    a_reset_quiet: assert property (!core_reset_n |-> !stop_mode)
        else $error("stop during reset");
    a_spi_wake: assert property (stop_mode && spi_enable && spi_cmp_enable && spi_cmp_match
        |=> !stop_mode && !core_reset_n) else $error("compare match did not wake");
    a_wake_keeps: assert property ($fell(stop_mode) && !$past(wdt_expire) |-> $stable(port3_mode_reg)
        && $stable(watchdog_mode_reg) && $stable(port2_mode_reg)) else $error("mode lost on wake");
    a_wake_tail: assert property ($fell(stop_mode) && !$past(wdt_expire) |-> !core_reset_n [*8])
        else $error("wake tail too short");
endmodule
bind stwc_top stwc_top_assertions u_stwc_top_assertions (.*);

// file: tb/stwc_top_tb.sv
// Purpose : self-checking bench for the stop-wake and port-config block
// Assumes : detectors tied low, reset delay shortened to 20 clocks
// Notes   : random values come from a bench lfsr with a fixed start
`timescale 1ns/1ps
module stwc_top_tb;
    import stwc_pkg::*;
    logic        clk_sys = 0, rstn = 0, wdt_expire = 0, stop_req = 0, reg_wr = 0, go = 0, warm = 0;
    logic        spi_enable = 0, spi_cmp_enable = 0, spi_cmp_match = 0, cmp_out_a = 0, cmp_out_b = 0;
    logic        port3_bit4_gpio = 0, port3_bit5_gpio = 0, port3_bit4_out, port3_bit5_out;
    logic        port2_low_noise, port3_low_noise, osc_low_noise, core_reset_n, stop_mode, sl;
    logic [3:0]  reg_bank = 0, reg_addr = 0;
    logic [7:0]  reg_wdata = 0, reg_rdata, watchdog_mode_reg, port2_mode_reg, port3_mode_reg, v, am;
    logic [7:0]  port2_pins;
    logic [3:1]  port3_pins;
    logic [10:0] idle_v = 11'h7ff, wake_v = 11'h7ff;
    logic [31:0] lfsr = 32'hd673;
    int          bad_count = 0, checks = 0, cyc = 0, n;
    stwc_top #(.DELAY_CYCLES(20)) u_stwc_top (.por_detect(1'b0), .lvp_detect(1'b0), .*);
    stwc_pins_model u_stwc_pins_model (.*);
    always #2 clk_sys = ~clk_sys;
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // pin that moves for each wake code, as {port 2, port 3 bits 3..1}
    function automatic logic [10:0] msk(input int c);
        return c == 2 ? 11'h001 : c == 3 ? 11'h002 : c == 4 ? 11'h004 : c == 5 ? 11'h400 : 11'h008;
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    // one write strobe, then an idle clock so strobes never touch
    task automatic wr(input logic [3:0] b, input logic [3:0] a, input logic [7:0] d);
        reg_bank = b; reg_addr = a; reg_wdata = d; reg_wr = 1;
        @(negedge clk_sys) reg_wr = 0;
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a);
        reg_bank = 4'hf; reg_addr = a;
        @(negedge clk_sys);
    endtask
    task automatic wrun;
        n = 0;
        while (core_reset_n !== 1'b1 && n < 100)
        begin
            @(negedge clk_sys);
            n++;
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // hang guard, well above the roughly 800 clocks the run needs
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            bad_count++;
            close_out;
        end
    end
    initial
    begin
        repeat (20) @(negedge clk_sys);
        rstn = 1;
        wrun; chk("boot", 8'h01, 8'(n > 36 && n < 42));
        rd(STWC_OFF_STOPWAKE); chk("swc_rst", STWC_STOPWAKE_RST, reg_rdata);
        chk("drv_rst", 8'h00, {port2_low_noise, port3_low_noise, osc_low_noise});
        repeat (8)
        begin
            lfsr = nx(lfsr);
            v = lfsr[7:0] | 8'h1e;
            {cmp_out_a, cmp_out_b, port3_bit4_gpio, port3_bit5_gpio} = lfsr[11:8];
            wr(4'hf, STWC_OFF_PORTDRV, v);
            rd(STWC_OFF_PORTDRV); chk("pdc_read", STWC_RD_WO, reg_rdata);
            chk("p3_route", v[0] ? lfsr[11:10] : lfsr[9:8], {port3_bit4_out, port3_bit5_out});
            wr(4'he, STWC_OFF_PORTDRV, ~v);
            chk("low_noise", {5'h0, ~v[7:5]}, {osc_low_noise, port3_low_noise, port2_low_noise});
        end
        $display("test drive config done");
        wr(4'hf, STWC_OFF_WDMODE, 8'h5a);
        wr(4'hf, STWC_OFF_P2MODE, 8'ha5);
        for (int c = 0; c < 8; c++)
            for (int l = 0; l < 2; l++)
            begin
                lfsr = nx(lfsr);
                v = {lfsr[7], l[0], l[0], c[2:0], 2'b00};
                am = {6'h0, c == 2 && l == 0, 1'b0};
                sl = c < 2 || am[1];
                idle_v = ((c < 6) ^ l[0]) ? (c < 6 ? 11'h7ff : 11'h008) : 11'h000;
                wake_v = idle_v ^ msk(c);
                wr(4'hf, STWC_OFF_P3MODE, am);
                wr(4'hf, STWC_OFF_STOPWAKE, v);
                rd(STWC_OFF_STOPWAKE); chk("swc_rw", {warm, v[6:0]}, reg_rdata);
                stop_req = 1;
                @(negedge clk_sys) stop_req = 0;
                warm = 1;
                go = 1;
                @(negedge clk_sys) go = 0;
                n = 0;
                while (stop_mode === 1'b1 && n < 12)
                begin
                    @(negedge clk_sys);
                    n++;
                end
                chk("asleep", 8'(sl), 8'(stop_mode));
                if (sl)
                begin
                    {spi_enable, spi_cmp_enable, spi_cmp_match} = 3'h7;
                    @(negedge clk_sys) chk("spi_wake", 8'h00, 8'(stop_mode));
                    {spi_enable, spi_cmp_enable, spi_cmp_match} = 3'h0;
                end
                wrun; chk("tail", 8'h01, 8'(l ? n > 35 && n < 41 : n > 15 && n < 21));
                chk("p3m_kept", am, port3_mode_reg);
                chk("wdm_kept", 8'h5a, watchdog_mode_reg);
                chk("p2m_kept", 8'ha5, port2_mode_reg);
            end
        $display("test wake sources done");
        wdt_expire = 1;
        @(negedge clk_sys) wdt_expire = 0;
        chk("wdt_rst", 8'h00, 8'(core_reset_n));
        wrun; rd(STWC_OFF_STOPWAKE); chk("swc_wdt", STWC_STOPWAKE_RST, reg_rdata);
        chk("wdm_wdt", STWC_WDMODE_RST, watchdog_mode_reg);
        chk("p2m_wdt", STWC_P2MODE_RST, port2_mode_reg);
        $display("test watchdog done");
        close_out;
    end
endmodule
